// ### logic/hspr_defs.svh
/*
 * constants for the host pin routing block: widths, pin counts, shift
 * lengths and reset values.
 * assumes it is included by bare name from every design file except the synchroniser.
 */
// Behaviour
// (RULE_01) share select 1 puts both slaves on one bus
// (RULE_02) standalone select 1 emulates state machine internally
// (RULE_03) undriven standalone select means host mode
// (RULE_04) interrupt output for process data interface
// (RULE_05) io block irq high when event pending
// (RULE_06) stop low forces outputs safe
// (RULE_07) stop stays latched until host clears
// (RULE_08) other party drives stop high normally
// (RULE_09) watchdog alive 0 expired, 1 running
// (RULE_10) watchdog kick flag 1 when triggered
// (RULE_11) frame start flag 1 on frame start
// (RULE_12) frame end flag 1 on frame end
// (RULE_13) run and error indicators active high
// (RULE_14) per port activity outputs active high
// (RULE_15) two timing pulse outputs to host
// (RULE_16) two time capture inputs, low if unused
// (RULE_17) second spi slave controls io block
// (RULE_18) sixteen two way general io pins
// (RULE_19) selects active low, idle slave releases dout
// (RULE_20) select straps sampled once after reset
`ifndef HSPR_DEFS_SVH
`define HSPR_DEFS_SVH

`define HSPR_GPIO_W     16
`define HSPR_SPI_W      8
`define HSPR_CNT_W      3
`define HSPR_CNT_LAST   3'h7
`define HSPR_CNT_ZERO   3'h0
`define HSPR_BYTE_ZERO  8'h00
`define HSPR_GPIO_ZERO  16'h0000
`define HSPR_STRAP_HOST 1'b0
`define HSPR_STRAP_SEP  1'b0

`endif

// ### logic/hspr_pkg.sv
/*
 * types shared by the host pin routing block.
 * assumes hspr_defs.svh is visible on the include path.
 */
`include "hspr_defs.svh"
package hspr_pkg;
	// strap capture state
	typedef enum logic [1:0] {HSPR_ST_RESET, HSPR_ST_FILL, HSPR_ST_CAPTURE,
		HSPR_ST_RUN} hspr_strap_e;
	// general io word
	typedef logic [`HSPR_GPIO_W-1:0] hspr_gpio_t;
	// spi byte
	typedef logic [`HSPR_SPI_W-1:0] hspr_byte_t;
endpackage : hspr_pkg

// ### logic/hspr_sync.sv
/*
 * two flip-flop synchroniser bank for pins from outside the clock domain.
 * assumes asynchronous active-low reset and a single system clock.
 */
`timescale 1ns/10ps
module hspr_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         i_sys_clk,
	input  wire logic         i_rstn,
	// data
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta;  // first stage, read only by the second

	// two stage capture
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			meta   <= '0;
			o_sync <= '0;
		end
		else
		begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end
endmodule : hspr_sync

// ### logic/hspr_spi_slave.sv
/*
 * spi mode 0 byte slave, msb first, clocked from the system clock by
 * sampling already synchronised serial clock, select and data.
 * assumes inputs come from hspr_sync; select is active low.
 */
`timescale 1ns/10ps
`include "hspr_defs.svh"
module hspr_spi_slave
	import hspr_pkg::*;
(
	// clock and reset
	input  wire logic               i_sys_clk,
	input  wire logic               i_rstn,
	// synchronised serial pins
	input  wire logic               i_sel_n,
	input  wire logic               i_sclk,
	input  wire logic               i_din,
	// byte side
	input  wire hspr_pkg::hspr_byte_t i_tx_byte,
	output hspr_pkg::hspr_byte_t    o_rx_byte,
	output logic                    o_rx_valid,
	output logic                    o_dout,
	output logic                    o_dout_oe
);
	logic                   sclk_d;  // previous serial clock
	logic [`HSPR_CNT_W-1:0] cnt;     // bit count within byte
	hspr_byte_t             shift_in;
	hspr_byte_t             shift_out;
	wire rise = i_sclk & ~sclk_d & ~i_sel_n;
	wire fall = ~i_sclk & sclk_d & ~i_sel_n;

	// shift on edges, reload when deselected
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			sclk_d     <= 1'b0;
			cnt        <= `HSPR_CNT_ZERO;
			shift_in   <= `HSPR_BYTE_ZERO;
			shift_out  <= `HSPR_BYTE_ZERO;
			o_rx_byte  <= `HSPR_BYTE_ZERO;
			o_rx_valid <= 1'b0;
			o_dout     <= 1'b0;
			o_dout_oe  <= 1'b0;
		end
		else
		begin
			sclk_d     <= i_sclk;
			o_rx_valid <= 1'b0;
			o_dout_oe  <= ~i_sel_n;  // released when deselected [RULE_19]
			if (i_sel_n)
			begin
				cnt       <= `HSPR_CNT_ZERO;
				shift_out <= i_tx_byte;
				o_dout    <= i_tx_byte[`HSPR_SPI_W-1];
			end
			else if (rise)
			begin
				shift_in <= {shift_in[`HSPR_SPI_W-2:0], i_din};
				cnt      <= cnt + 1'b1;
				if (cnt == `HSPR_CNT_LAST)
				begin
					o_rx_byte  <= {shift_in[`HSPR_SPI_W-2:0], i_din};
					o_rx_valid <= 1'b1;
				end
			end
			else if (fall)
			begin
				// next bit out; reload at byte boundary
				if (cnt == `HSPR_CNT_ZERO)
				begin
					shift_out <= i_tx_byte;
					o_dout    <= i_tx_byte[`HSPR_SPI_W-1];
				end
				else
				begin
					shift_out <= {shift_out[`HSPR_SPI_W-2:0], 1'b0};
					o_dout    <= shift_out[`HSPR_SPI_W-2];
				end
			end
		end
	end
endmodule : hspr_spi_slave

// ### logic/hspr_pin_routing.sv
/*
 * host-facing pin logic: routes the process-data and io-control spi slaves
 * over separate or shared buses, captures straps, latches the emergency
 * stop, and registers every status and indicator output.
 * assumes a 100 MHz system clock, all pins asynchronous to it, and that
 * the internal functions behind each output arrive as same-clock inputs.
 */
`timescale 1ns/10ps
`include "hspr_defs.svh"
module hspr_pin_routing
	import hspr_pkg::*;
(
	// clock and reset
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_rstn,
	// strap pins
	input  wire logic                 i_bus_share_select,
	input  wire logic                 i_standalone_select,
	// process data spi pins
	input  wire logic                 i_host_link_select_n,
	input  wire logic                 i_host_link_sclk,
	input  wire logic                 i_host_link_din,
	output logic                      o_host_link_dout,
	output logic                      o_host_link_dout_oe,
	// io control spi pins
	input  wire logic                 i_io_ctrl_select_n,
	input  wire logic                 i_io_ctrl_sclk,
	input  wire logic                 i_io_ctrl_din,
	output logic                      o_io_ctrl_dout,
	output logic                      o_io_ctrl_dout_oe,
	// byte side of both slaves
	input  wire hspr_pkg::hspr_byte_t i_pd_tx_byte,
	output hspr_pkg::hspr_byte_t      o_pd_rx_byte,
	output logic                      o_pd_rx_valid,
	input  wire hspr_pkg::hspr_byte_t i_io_tx_byte,
	output hspr_pkg::hspr_byte_t      o_io_rx_byte,
	output logic                      o_io_rx_valid,
	// mode status
	output logic                      o_shared_mode,
	output logic                      o_standalone_mode,
	// emergency stop
	input  wire logic                 i_emergency_stop_n,
	input  wire logic                 i_stop_clear,
	output logic                      o_stop_latched,
	// internal events to pins
	input  wire logic                 i_pd_irq_req,
	input  wire logic                 i_io_event_pending,
	input  wire logic                 i_wd_expired,
	input  wire logic                 i_wd_kick,
	input  wire logic                 i_frame_start,
	input  wire logic                 i_frame_end,
	input  wire logic                 i_run,
	input  wire logic                 i_error,
	input  wire logic                 i_in_activity,
	input  wire logic                 i_out_activity,
	input  wire logic                 i_timing_pulse0,
	input  wire logic                 i_timing_pulse1,
	output logic                      o_host_link_irq,
	output logic                      o_io_block_irq,
	output logic                      o_watchdog_alive,
	output logic                      o_watchdog_kick_flag,
	output logic                      o_frame_start_flag,
	output logic                      o_frame_end_flag,
	output logic                      o_run_indicator,
	output logic                      o_error_indicator,
	output logic                      o_port_in_activity,
	output logic                      o_port_out_activity,
	output logic                      o_timing_pulse_out0,
	output logic                      o_timing_pulse_out1,
	// time capture pins
	input  wire logic                 i_time_capture_in0,
	input  wire logic                 i_time_capture_in1,
	output logic                      o_time_capture0,
	output logic                      o_time_capture1,
	// general low voltage io
	input  wire hspr_pkg::hspr_gpio_t i_gp_lv_io,
	input  wire hspr_pkg::hspr_gpio_t i_gp_out,
	input  wire hspr_pkg::hspr_gpio_t i_gp_dir,
	input  wire hspr_pkg::hspr_gpio_t i_gp_safe,
	output hspr_pkg::hspr_gpio_t      o_gp_lv_io,
	output hspr_pkg::hspr_gpio_t      o_gp_lv_io_oe,
	output hspr_pkg::hspr_gpio_t      o_gp_in
);
	////////////////////////////////////////////////////////////////////////
	// synchronisers for every outside pin

	localparam int NSYNC = 11;
	logic [NSYNC-1:0] pin_raw;  // raw pin bundle
	logic [NSYNC-1:0] pin_s;    // synchronised bundle
	hspr_gpio_t       gp_s;     // synchronised general io

	// selects enter inverted so a synchroniser held in reset reads as deselected
	assign pin_raw = {i_bus_share_select, i_standalone_select, ~i_host_link_select_n,
		i_host_link_sclk, i_host_link_din, ~i_io_ctrl_select_n, i_io_ctrl_sclk,
		i_io_ctrl_din, i_emergency_stop_n, i_time_capture_in0, i_time_capture_in1};

	hspr_sync #(.W(NSYNC)) u_pin_sync (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_async   (pin_raw),
		.o_sync    (pin_s)
	);

	hspr_sync #(.W(`HSPR_GPIO_W)) u_gp_sync (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_async   (i_gp_lv_io),
		.o_sync    (gp_s)
	);

	// named views of the bundle
	wire share_s   = pin_s[10];
	wire alone_s   = pin_s[9];
	wire pd_sel_n  = ~pin_s[8];
	wire pd_sclk   = pin_s[7];
	wire pd_din    = pin_s[6];
	wire io_sel_n  = ~pin_s[5];
	wire io_sclk_p = pin_s[4];
	wire io_din_p  = pin_s[3];
	wire estop_n   = pin_s[2];
	wire cap0_s    = pin_s[1];
	wire cap1_s    = pin_s[0];

	////////////////////////////////////////////////////////////////////////
	// strap capture after reset release

	hspr_strap_e state;  // capture sequencer
	logic        shared; // held bus share mode
	logic        alone;  // held standalone mode

	// one capture once synchronisers have filled
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state  <= HSPR_ST_RESET;
			shared <= `HSPR_STRAP_SEP;
			alone  <= `HSPR_STRAP_HOST;  // pulled-down default is host mode [RULE_03]
		end
		else
		begin
			case (state)
				HSPR_ST_RESET:   state <= HSPR_ST_FILL;
				// second stage still shows its reset value here
				HSPR_ST_FILL:    state <= HSPR_ST_CAPTURE;
				HSPR_ST_CAPTURE:
				begin
					shared <= share_s;  // captured once, held after [RULE_20]
					alone  <= alone_s;
					state  <= HSPR_ST_RUN;
				end
				default:         state <= HSPR_ST_RUN;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// spi routing

	wire io_sclk = shared ? pd_sclk : io_sclk_p;  // shared bus uses pd lines [RULE_01]
	wire io_din  = shared ? pd_din : io_din_p;
	wire pd_sel_eff = pd_sel_n | alone;  // standalone disables host pd slave [RULE_02]

	logic pd_dout;
	logic pd_oe;
	logic io_dout;
	logic io_oe;

	hspr_spi_slave u_pd_spi (
		.i_sys_clk  (i_sys_clk),
		.i_rstn     (i_rstn),
		.i_sel_n    (pd_sel_eff),
		.i_sclk     (pd_sclk),
		.i_din      (pd_din),
		.i_tx_byte  (i_pd_tx_byte),
		.o_rx_byte  (o_pd_rx_byte),
		.o_rx_valid (o_pd_rx_valid),
		.o_dout     (pd_dout),
		.o_dout_oe  (pd_oe)
	);

	// io control slave [RULE_17]
	hspr_spi_slave u_io_spi (
		.i_sys_clk  (i_sys_clk),
		.i_rstn     (i_rstn),
		.i_sel_n    (io_sel_n),
		.i_sclk     (io_sclk),
		.i_din      (io_din),
		.i_tx_byte  (i_io_tx_byte),
		.o_rx_byte  (o_io_rx_byte),
		.o_rx_valid (o_io_rx_valid),
		.o_dout     (io_dout),
		.o_dout_oe  (io_oe)
	);

	// shared mode: io slave answers on pd data-out line [RULE_01] [RULE_19]
	wire next_pd_dout = (shared && io_oe) ? io_dout : pd_dout;
	wire next_pd_oe   = pd_oe | (shared & io_oe);
	wire next_io_dout = shared ? 1'b0 : io_dout;
	wire next_io_oe   = shared ? 1'b0 : io_oe;

	////////////////////////////////////////////////////////////////////////
	// emergency stop latch

	logic stop;  // latched stop event
	// set wins over clear; low input keeps it set [RULE_07]
	wire next_stop = ~estop_n | (stop & ~i_stop_clear);

	////////////////////////////////////////////////////////////////////////
	// general io drive, per pin

	hspr_gpio_t next_gp_out;
	genvar g;
	generate
		for (g = 0; g < `HSPR_GPIO_W; g++)
		begin : g_gp
			// safe value while stopped [RULE_06] [RULE_18]
			assign next_gp_out[g] = next_stop ? i_gp_safe[g] : i_gp_out[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// output registers

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			stop                 <= 1'b1;
			o_stop_latched       <= 1'b1;
			o_host_link_dout     <= 1'b0;
			o_host_link_dout_oe  <= 1'b0;
			o_io_ctrl_dout       <= 1'b0;
			o_io_ctrl_dout_oe    <= 1'b0;
			o_shared_mode        <= 1'b0;
			o_standalone_mode    <= 1'b0;
			o_host_link_irq      <= 1'b0;
			o_io_block_irq       <= 1'b0;
			o_watchdog_alive     <= 1'b0;
			o_watchdog_kick_flag <= 1'b0;
			o_frame_start_flag   <= 1'b0;
			o_frame_end_flag     <= 1'b0;
			o_run_indicator      <= 1'b0;
			o_error_indicator    <= 1'b0;
			o_port_in_activity   <= 1'b0;
			o_port_out_activity  <= 1'b0;
			o_timing_pulse_out0  <= 1'b0;
			o_timing_pulse_out1  <= 1'b0;
			o_time_capture0      <= 1'b0;
			o_time_capture1      <= 1'b0;
			o_gp_lv_io           <= `HSPR_GPIO_ZERO;
			o_gp_lv_io_oe        <= `HSPR_GPIO_ZERO;
			o_gp_in              <= `HSPR_GPIO_ZERO;
		end
		else
		begin
			stop                 <= next_stop;             // [RULE_06] [RULE_07]
			o_stop_latched       <= next_stop;
			o_host_link_dout     <= next_pd_dout;          // [RULE_19]
			o_host_link_dout_oe  <= next_pd_oe;
			o_io_ctrl_dout       <= next_io_dout;
			o_io_ctrl_dout_oe    <= next_io_oe;
			o_shared_mode        <= shared;                // [RULE_01]
			o_standalone_mode    <= alone;                 // [RULE_02]
			o_host_link_irq      <= i_pd_irq_req;          // [RULE_04]
			o_io_block_irq       <= i_io_event_pending;    // [RULE_05]
			o_watchdog_alive     <= ~i_wd_expired;         // [RULE_09]
			o_watchdog_kick_flag <= i_wd_kick;             // [RULE_10]
			o_frame_start_flag   <= i_frame_start;         // [RULE_11]
			o_frame_end_flag     <= i_frame_end;           // [RULE_12]
			o_run_indicator      <= i_run;                 // [RULE_13]
			o_error_indicator    <= i_error;               // [RULE_13]
			o_port_in_activity   <= i_in_activity;         // [RULE_14]
			o_port_out_activity  <= i_out_activity;        // [RULE_14]
			o_timing_pulse_out0  <= i_timing_pulse0;       // [RULE_15]
			o_timing_pulse_out1  <= i_timing_pulse1;       // [RULE_15]
			o_time_capture0      <= cap0_s;                // [RULE_16]
			o_time_capture1      <= cap1_s;                // [RULE_16]
			o_gp_lv_io           <= next_gp_out;           // [RULE_18]
			o_gp_lv_io_oe        <= i_gp_dir;
			o_gp_in              <= gp_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	stop_holds_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [RULE_07]
		(stop && !i_stop_clear) |=> stop)
		else $error("stop latch released without clear");

	stop_sets_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [RULE_06]
		!estop_n |=> (stop && o_gp_lv_io == $past(i_gp_safe)))
		else $error("stop low did not force safe outputs");

	wd_alive_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [RULE_09]
		i_wd_expired |=> !o_watchdog_alive)
		else $error("watchdog alive while expired");

	irq_follow_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [RULE_05]
		i_io_event_pending |=> o_io_block_irq)
		else $error("io irq not raised");

	strap_hold_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [RULE_20]
		(state == HSPR_ST_RUN) |=> $stable(shared) && $stable(alone))
		else $error("strap changed after capture");

	shared_route_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [RULE_01]
		shared |=> !o_io_ctrl_dout_oe)
		else $error("io dout driven in shared mode");

	idle_release_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [RULE_19]
		(pd_sel_eff && io_sel_n) |-> ##2 !o_host_link_dout_oe)
		else $error("dout driven while deselected");

	alone_mute_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [RULE_02]
		alone |-> !o_pd_rx_valid)
		else $error("pd slave active in standalone");

endmodule : hspr_pin_routing

// ### sim/hspr_spi_master.sv
/*
 * behavioural spi mode 0 master standing in for the host controller.
 * assumes the bench resolves the data-in line from all slave enables.
 */
`timescale 1ns/10ps
module hspr_spi_master (
	// serial lines toward the slaves
	output logic      o_pd_sel_n,
	output logic      o_io_sel_n,
	output logic      o_sclk,
	output logic      o_din,
	// resolved data line from the slaves
	input  wire logic i_dout
);
	localparam realtime HALF = 62.5; // half of the 125 ns serial clock
	// idle: both deselected, clock parked low
	initial
	begin
		o_pd_sel_n = 1'b1;
		o_io_sel_n = 1'b1;
		o_sclk     = 1'b0;
		o_din      = 1'b0;
	end
	// one whole byte, msb first, clock still outside the frame
	task xfer(input logic sel_io, input logic [7:0] tx, output logic [7:0] rx);
		rx = 8'h00;
		if (sel_io) o_io_sel_n = 1'b0; // only one select low at a time
		else o_pd_sel_n = 1'b0; // only one select low at a time
		#HALF;
		for (int i = 7; i >= 0; i--)
		begin
			o_din = tx[i]; // data set while clock low
			#HALF o_sclk = 1'b1;
			rx[i] = i_dout; // sampled on rising serial edge
			#HALF o_sclk = 1'b0;
		end
		#HALF;
		o_pd_sel_n = 1'b1;
		o_io_sel_n = 1'b1;
		o_din = ~tx[0]; // released line must not look like the last bit
		#(4*HALF);
	endtask : xfer
endmodule : hspr_spi_master

// ### sim/tb_hspr_pin_routing.sv
/*
 * self-checking bench for the host pin routing block.
 * assumes the spi master model and the design files are compiled first.
 */
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_fail++; \
	$display("mismatch %s exp %0h got %0h", nm, ex, gt); end end
module tb_hspr_pin_routing;
	import hspr_pkg::*;
	logic       clk, rstn, share, alone, bus_sh, estop_n, clr, cap0, cap1, io_oe_seen;
	logic       pd_dout, pd_oe, io_dout, io_oe, pd_v, io_v, sh_m, sa_m, stop_l, c_o0, c_o1;
	logic       m_pd_sel_n, m_io_sel_n, m_sclk, m_din, miso, pd_sclk, io_sclk;
	logic [11:0] st_in;  // status inputs
	wire  [11:0] st_out; // status pins, one driver per bit
	hspr_byte_t pd_tx, io_tx, pd_rx, io_rx, pd_got, io_got;
	hspr_gpio_t gp_pin, gp_out, gp_dir, gp_safe, gp_o, gp_oe, gp_in;
	int         pd_n, io_n, n_fail, check_count;
	////////////////////////////////////////////////////////////////////
	// clock, line resolution and routing of the serial pins
	always #5 clk = ~clk;
	assign miso    = pd_oe ? pd_dout : (io_oe ? io_dout : clk); // released: toggles
	assign pd_sclk = m_sclk & (bus_sh | m_io_sel_n);
	assign io_sclk = m_sclk & ~bus_sh; // io clock pin held low in shared wiring
	hspr_spi_master u_master (.o_pd_sel_n(m_pd_sel_n), .o_io_sel_n(m_io_sel_n),
		.o_sclk(m_sclk), .o_din(m_din), .i_dout(miso));
	hspr_pin_routing DUT (.i_sys_clk(clk), .i_rstn(rstn), .i_bus_share_select(share),
		.i_standalone_select(alone), .i_host_link_select_n(m_pd_sel_n),
		.i_host_link_sclk(pd_sclk), .i_host_link_din(m_din), .o_host_link_dout(pd_dout),
		.o_host_link_dout_oe(pd_oe), .i_io_ctrl_select_n(m_io_sel_n),
		.i_io_ctrl_sclk(io_sclk), .i_io_ctrl_din(m_din), .o_io_ctrl_dout(io_dout),
		.o_io_ctrl_dout_oe(io_oe), .i_pd_tx_byte(pd_tx), .o_pd_rx_byte(pd_rx),
		.o_pd_rx_valid(pd_v), .i_io_tx_byte(io_tx), .o_io_rx_byte(io_rx),
		.o_io_rx_valid(io_v), .o_shared_mode(sh_m), .o_standalone_mode(sa_m),
		.i_emergency_stop_n(estop_n), .i_stop_clear(clr), .o_stop_latched(stop_l),
		.i_pd_irq_req(st_in[11]), .i_io_event_pending(st_in[10]), .i_wd_expired(st_in[9]),
		.i_wd_kick(st_in[8]), .i_frame_start(st_in[7]), .i_frame_end(st_in[6]),
		.i_run(st_in[5]), .i_error(st_in[4]), .i_in_activity(st_in[3]),
		.i_out_activity(st_in[2]), .i_timing_pulse0(st_in[1]), .i_timing_pulse1(st_in[0]),
		.o_host_link_irq(st_out[11]), .o_io_block_irq(st_out[10]),
		.o_watchdog_alive(st_out[9]), .o_watchdog_kick_flag(st_out[8]),
		.o_frame_start_flag(st_out[7]), .o_frame_end_flag(st_out[6]),
		.o_run_indicator(st_out[5]), .o_error_indicator(st_out[4]),
		.o_port_in_activity(st_out[3]), .o_port_out_activity(st_out[2]),
		.o_timing_pulse_out0(st_out[1]), .o_timing_pulse_out1(st_out[0]),
		.i_time_capture_in0(cap0), .i_time_capture_in1(cap1), .o_time_capture0(c_o0),
		.o_time_capture1(c_o1), .i_gp_lv_io(gp_pin), .i_gp_out(gp_out), .i_gp_dir(gp_dir),
		.i_gp_safe(gp_safe), .o_gp_lv_io(gp_o), .o_gp_lv_io_oe(gp_oe), .o_gp_in(gp_in));
	////////////////////////////////////////////////////////////////////
	// catch one-cycle byte strobes and any io drive
	always @(posedge clk)
	begin
		if (pd_v === 1'b1)
		begin
			pd_got <= pd_rx;
			pd_n   <= pd_n + 1;
		end
		if (io_v === 1'b1)
		begin
			io_got <= io_rx;
			io_n   <= io_n + 1;
		end
		if (io_oe === 1'b1) io_oe_seen <= 1'b1;
	end
	////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : wrap_up
	// reset with straps held, then settle past strap capture
	task do_reset(input logic sh, input logic sa);
		rstn = 1'b0;
		share = sh;
		alone = sa;
		bus_sh = sh;
		repeat (5) @(negedge clk);
		`CHK("rst_stop", 1'b1, stop_l)
		`CHK("rst_status", 12'h000, st_out)
		pd_n = 0;
		io_n = 0;
		io_oe_seen = 1'b0;
		rstn = 1'b1;
		repeat (10) @(negedge clk);
	endtask : do_reset
	// one byte through the master, with expected result
	task spi_chk(input logic io, input hspr_byte_t mosi, input hspr_byte_t resp,
		input logic want);
		hspr_byte_t rx;
		int         n0;
		n0 = io ? io_n : pd_n;
		if (io) io_tx = resp;
		else pd_tx = resp;
		u_master.xfer(io, mosi, rx);
		repeat (8) @(negedge clk);
		if (want)
		begin
			`CHK("miso", resp, rx)
			`CHK("rx_byte", mosi, io ? io_got : pd_got)
			`CHK("rx_count", n0 + 1, io ? io_n : pd_n)
		end
		else `CHK("rx_count", n0, io ? io_n : pd_n)
	endtask : spi_chk
	////////////////////////////////////////////////////////////////////
	// watchdog against a hang
	initial
	begin
		#100000;
		n_fail++;
		wrap_up();
	end
	// main sequence
	initial
	begin
		clk = 0; rstn = 0; share = 0; alone = 0; bus_sh = 0; clr = 0; pd_tx = 8'h00;
		estop_n = 1'b1; // held high for normal running
		cap0 = 0; cap1 = 0; // unused capture pin tied low
		io_tx = 8'h00; st_in = 12'h000; gp_pin = 16'h0000; gp_out = 16'h1234;
		gp_dir = 16'h00FF; gp_safe = 16'hF00F; pd_n = 0; io_n = 0; io_oe_seen = 0;
		pd_got = 8'h00; io_got = 8'h00; n_fail = 0; check_count = 0;
		do_reset(1'b0, 1'b0);
		`CHK("modes", 2'b00, {sh_m, sa_m})
		spi_chk(1'b0, 8'hC5, 8'h3A, 1'b1);
		spi_chk(1'b1, 8'h81, 8'h7E, 1'b1);
		`CHK("io_oe", 1'b1, io_oe_seen)
		for (int k = 0; k < 2; k++)
		begin
			st_in = k ? 12'h5A3 : 12'hA5C;
			repeat (3) @(negedge clk);
			`CHK("status", st_in ^ 12'h200, st_out)
			`CHK("status", st_in ^ 12'h200, st_out)
		end
		`CHK("gp_oe", gp_dir, gp_oe)
		gp_pin = 16'hA5C3;
		cap0 = 1'b1;
		repeat (5) @(negedge clk);
		`CHK("gp_in", gp_pin, gp_in)
		`CHK("capture", 2'b01, {c_o1, c_o0})
		`CHK("safe", gp_safe, gp_o)
		clr = 1'b1;
		@(negedge clk);
		clr = 1'b0;
		repeat (4) @(negedge clk);
		`CHK("stop", 1'b0, stop_l)
		`CHK("gp", gp_out, gp_o)
		estop_n = 1'b0;
		clr = 1'b1;
		repeat (6) @(negedge clk);
		`CHK("stop", 1'b1, stop_l)
		`CHK("safe", gp_safe, gp_o)
		clr = 1'b0;
		estop_n = 1'b1;
		repeat (6) @(negedge clk);
		`CHK("stop", 1'b1, stop_l)
		clr = 1'b1;
		@(negedge clk);
		clr = 1'b0;
		repeat (4) @(negedge clk);
		`CHK("stop", 1'b0, stop_l)
		do_reset(1'b1, 1'b0);
		share = 1'b0;
		repeat (5) @(negedge clk);
		`CHK("shared", 1'b1, sh_m)
		spi_chk(1'b1, 8'h5C, 8'hA3, 1'b1);
		spi_chk(1'b0, 8'h96, 8'h69, 1'b1);
		`CHK("io_oe", 1'b0, io_oe_seen)
		do_reset(1'b0, 1'b1);
		`CHK("alone", 1'b1, sa_m)
		spi_chk(1'b0, 8'hAA, 8'h55, 1'b0);
		wrap_up();
	end
endmodule : tb_hspr_pin_routing
